// [inc/mdt_pkg.sv]
// Constants and types shared by the multimode down timer
package mdt_pkg;
  // Byte addresses of the timer registers in the core's data space
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hAA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hAB;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hAC;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hAD;
  localparam logic [7:0] ADDR_CONTROL     = 8'hAE;
  // Reset values
  localparam logic [15:0] COUNT_RESET   = 16'hFFFF;
  localparam logic [15:0] RELOAD_RESET  = 16'h0000;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  // Control field positions
  localparam int MODE_HI_BIT   = 7;
  localparam int MODE_MID_BIT  = 6;
  localparam int MODE_EDGE_BIT = 5;
  localparam int RUN_BIT       = 4;
  localparam int PEND_BIT      = 3;
  localparam int IRQ_EN_BIT    = 2;
  // Writable control bits; bits 1..0 read as zero
  localparam logic [7:0] CONTROL_MASK = 8'hFC;
  // Mode field values, bits 7..6 (bit 5 is edge or toggle)
  localparam logic [1:0] MODE_EVENT   = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;

  typedef enum logic [1:0] {
    MDT_EVENT,
    MDT_CAPTURE,
    MDT_PWM,
    MDT_UNUSED
  } mdt_mode_e;
endpackage

// [hdl/mdt_timer.sv]
// Multimode 16-bit down timer with byte-wide register access
// How it works
// - Running counter decrements once per timer tick
// - Reset: count FFFF, reload 0000, control 00
// - Bit 4 runs counter outside capture mode
// - Underflow in PWM/event reloads from reload register
// - Pending bit 3 set on underflow or capture
// - Bit 2 enables the timer interrupt
// - Interrupt needs timer and global enable
// - Interrupt only on flag going clear to set
// - Bits 7..6 choose event, PWM or capture
// - Instruction clock ticks, pin edges in event mode
// - Capture mode: bit 4 is underflow flag
// - PWM toggle mode inverts pin each underflow
// - Timer pin shares the general I/O pin
// - Interrupt source follows the selected mode
// - Sixteen-bit registers accessed as byte pairs
// - Capture copies count on selected edge
// - Capture mode counts continuously on instruction clock
// - Pin levels need two clocks, quarter-rate max
module mdt_timer
  import mdt_pkg::*;
(
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESET_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       GLOBAL_IRQ_EN_I,
  output logic            TIMER_IRQ_O,
  input  wire logic       SHARED_IO_PIN_I,
  input  wire logic       GPIO_OUT_I,
  input  wire logic       GPIO_OE_N_I,
  input  wire logic       GPIO_DATA_WR_I,
  output logic            SHARED_IO_PIN_O,
  output logic            SHARED_IO_PIN_OE_N_O
);
  import mdt_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0]  control;
    logic [2:0]  pin_sync;
    logic        pin_prev;
    logic        pin_out;
    logic [7:0]  rdata;
    logic        irq;
  } mdt_state_s;

  mdt_state_s state_r;
  mdt_state_s state_nxt;

  // Decode the mode field once for the whole block
  function automatic mdt_mode_e decode_mode(input logic [7:0] ctl);
    mdt_mode_e m;
    m = MDT_UNUSED;
    // Mode field decode; bit 5 is edge or toggle
    case (ctl[MODE_HI_BIT:MODE_MID_BIT])
      MODE_EVENT:
      begin
        m = MDT_EVENT;
      end
      MODE_CAPTURE:
      begin
        m = MDT_CAPTURE;
      end
      MODE_PWM:
      begin
        m = MDT_PWM;
      end
      default:
      begin
        // 11x is unused: stop and flag nothing
        m = MDT_UNUSED;
      end
    endcase
    return m;
  endfunction

  // Register select decoded from the byte address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_RELOAD_LOW,
    SEL_RELOAD_HIGH,
    SEL_COUNT_LOW,
    SEL_COUNT_HIGH,
    SEL_CONTROL
  } mdt_sel_e;

  // One address decode shared by reads and writes
  function automatic mdt_sel_e decode_addr(input logic [7:0] addr);
    mdt_sel_e s;
    s = SEL_NONE;
    if (addr == ADDR_RELOAD_LOW)
    begin
      s = SEL_RELOAD_LOW;
    end
    else if (addr == ADDR_RELOAD_HIGH)
    begin
      s = SEL_RELOAD_HIGH;
    end
    else if (addr == ADDR_COUNT_LOW)
    begin
      s = SEL_COUNT_LOW;
    end
    else if (addr == ADDR_COUNT_HIGH)
    begin
      s = SEL_COUNT_HIGH;
    end
    else if (addr == ADDR_CONTROL)
    begin
      s = SEL_CONTROL;
    end
    return s;
  endfunction

  // Pin sampling and edge detection
  logic        pin_level;
  logic        pin_rise;
  logic        pin_fall;
  logic        edge_hit;

  // Counting
  mdt_mode_e   mode;
  logic        tick;
  logic        running;
  logic        underflow;
  logic [15:0] count_dec;

  // Bus and flags
  mdt_sel_e    wr_sel;
  mdt_sel_e    rd_sel;
  logic        count_wr;
  logic [7:0]  ctl_new;
  logic        pend_set;
  logic        uflag_set;
  logic        irq_rise;
  logic        irq_allow;

  always_comb
  begin
    state_nxt = state_r;
    mode      = decode_mode(state_r.control);
    // Strobes qualify the shared address decode
    wr_sel    = WR_I ? decode_addr(ADDR_I) : SEL_NONE;
    rd_sel    = RD_I ? decode_addr(ADDR_I) : SEL_NONE;
    count_wr  = (wr_sel == SEL_COUNT_LOW) ||
                (wr_sel == SEL_COUNT_HIGH);
    // Stable once second and third stages agree
    pin_level = state_r.pin_prev;
    if (state_r.pin_sync[1] == state_r.pin_sync[2])
    begin
      pin_level = state_r.pin_sync[2];
    end
    // One tick per selected edge, quarter clock rate max
    pin_rise  = pin_level & ~state_r.pin_prev;
    pin_fall  = ~pin_level & state_r.pin_prev;
    edge_hit  = state_r.control[MODE_EDGE_BIT] ? pin_fall : pin_rise;
    state_nxt.pin_sync = {state_r.pin_sync[1:0], SHARED_IO_PIN_I};
    state_nxt.pin_prev = pin_level;

    tick = 1'b0;
    case (mode)
      MDT_EVENT:
      begin
        // Selected pin edges only
        tick = edge_hit;
      end
      MDT_CAPTURE:
      begin
        // Free-running on every clock
        tick = 1'b1;
      end
      MDT_PWM:
      begin
        tick = 1'b1;
      end
      default:
      begin
        // Unused modes hold the count
        tick = 1'b0;
      end
    endcase
    // Run bit gates counting; capture always runs
    running   = (mode == MDT_CAPTURE) || state_r.control[RUN_BIT];
    underflow = running && tick && (state_r.count == COUNT_ZERO);
    count_dec = state_r.count - COUNT_ONE;

    // Register writes, byte at a time
    ctl_new = state_r.control;
    if (WR_I)
    begin
      if (wr_sel == SEL_RELOAD_LOW)
      begin
        state_nxt.reload[7:0] = WDATA_I;
      end
      else if (wr_sel == SEL_RELOAD_HIGH)
      begin
        state_nxt.reload[15:8] = WDATA_I;
      end
      else if (wr_sel == SEL_COUNT_LOW)
      begin
        state_nxt.count[7:0] = WDATA_I;
      end
      else if (wr_sel == SEL_COUNT_HIGH)
      begin
        state_nxt.count[15:8] = WDATA_I;
      end
      else if (wr_sel == SEL_CONTROL)
      begin
        // Control bits 1..0 are not stored
        ctl_new = WDATA_I & CONTROL_MASK;
      end
    end

    // Counter; a software write to the count wins over a tick
    if (running && tick && !count_wr)
    begin
      // Reload on underflow in PWM and event modes
      if (underflow && mode != MDT_CAPTURE)
      begin
        state_nxt.count = state_r.reload;
      end
      else
      begin
        state_nxt.count = count_dec;
      end
    end

    // Capture copies count, takes priority over writes
    if (mode == MDT_CAPTURE && edge_hit)
    begin
      state_nxt.reload = state_r.count;
    end

    // Flag sources per mode; set wins over a clear
    pend_set  = 1'b0;
    if (mode == MDT_CAPTURE)
    begin
      pend_set = edge_hit;
    end
    else if (mode != MDT_UNUSED)
    begin
      pend_set = underflow;
    end
    uflag_set = (mode == MDT_CAPTURE) && underflow;
    if (pend_set)
    begin
      ctl_new[PEND_BIT] = 1'b1;
    end
    if (uflag_set)
    begin
      ctl_new[RUN_BIT] = 1'b1;
    end
    state_nxt.control = ctl_new;

    // Toggle pin on underflow in PWM toggle mode
    if (GPIO_DATA_WR_I)
    begin
      state_nxt.pin_out = GPIO_OUT_I;
    end
    else if (underflow && mode == MDT_PWM &&
             state_r.control[MODE_EDGE_BIT])
    begin
      state_nxt.pin_out = ~state_r.pin_out;
    end

    // Only a clear-to-set flag edge raises a request
    irq_rise  = (pend_set && !state_r.control[PEND_BIT]) ||
                (uflag_set && !state_r.control[RUN_BIT]);
    // Timer and global enables both needed
    irq_allow = state_r.control[IRQ_EN_BIT] && GLOBAL_IRQ_EN_I;
    state_nxt.irq = irq_allow && irq_rise;

    // Read data; unmapped addresses return zero
    // Registered, so a read answers one cycle late and tears 16 bits
    state_nxt.rdata = 8'h00;
    if (RD_I)
    begin
      if (rd_sel == SEL_RELOAD_LOW)
      begin
        state_nxt.rdata = state_r.reload[7:0];
      end
      else if (rd_sel == SEL_RELOAD_HIGH)
      begin
        state_nxt.rdata = state_r.reload[15:8];
      end
      else if (rd_sel == SEL_COUNT_LOW)
      begin
        state_nxt.rdata = state_r.count[7:0];
      end
      else if (rd_sel == SEL_COUNT_HIGH)
      begin
        state_nxt.rdata = state_r.count[15:8];
      end
      else if (rd_sel == SEL_CONTROL)
      begin
        state_nxt.rdata = state_r.control;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      state_r.count    <= COUNT_RESET;
      state_r.reload   <= RELOAD_RESET;
      state_r.control  <= CONTROL_RESET;
      // Sampler idles high like the pin pull-up: no false edge
      state_r.pin_sync <= 3'h7;
      state_r.pin_prev <= 1'b1;
      state_r.pin_out  <= 1'b0;
      state_r.rdata    <= 8'h00;
      state_r.irq      <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Data outputs straight from flops
  assign RDATA_O     = state_r.rdata;
  assign TIMER_IRQ_O = state_r.irq;
  // Pin direction owned by the I/O port setting
  assign SHARED_IO_PIN_O      = state_r.pin_out;
  assign SHARED_IO_PIN_OE_N_O = GPIO_OE_N_I;
endmodule

// [tb/mdt_timer_sva.sv]
// Port assertions for the multimode down timer
module mdt_timer_sva
  import mdt_pkg::*;
(
  input wire logic       CORE_CLK_I,
  input wire logic       RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       GLOBAL_IRQ_EN_I,
  input wire logic       TIMER_IRQ_O,
  input wire logic       GPIO_OE_N_I,
  input wire logic       SHARED_IO_PIN_OE_N_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);
  chk_read_idle: assert property (
    !RD_I |=> RDATA_O == 8'h00) else $error("read data not idle");
  chk_irq_pulse: assert property (
    TIMER_IRQ_O |=> !TIMER_IRQ_O) else $error("irq too long");
  chk_irq_global: assert property (
    !GLOBAL_IRQ_EN_I [*2] |-> !TIMER_IRQ_O) else $error("irq masked");
  chk_oe_pass: assert property (
    SHARED_IO_PIN_OE_N_O == GPIO_OE_N_I) else $error("pin enable lost");
  chk_unmapped_read: assert property (
    RD_I && (ADDR_I < ADDR_RELOAD_LOW || ADDR_I > ADDR_CONTROL)
    |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
  chk_ctrl_spare: assert property (
    RD_I && ADDR_I == ADDR_CONTROL |=> RDATA_O[1:0] == 2'h0)
    else $error("spare control bits set");
  chk_reset_count: assert property (
    RD_I && ADDR_I == ADDR_COUNT_HIGH && $past(RESET_I)
    |=> RDATA_O == 8'hFF) else $error("count not FFFF at reset");
  chk_mode_back: assert property (
    WR_I && ADDR_I == ADDR_CONTROL ##1 RD_I && ADDR_I == ADDR_CONTROL
    |=> ((RDATA_O ^ $past(WDATA_I, 2)) & 8'hE4) == 8'h00)
    else $error("control readback wrong");
endmodule
bind mdt_timer mdt_timer_sva chk (.*);

// [tb/mdt_pin_source.sv]
// External pulse source on the shared timer pin
module mdt_pin_source (
  input  wire logic clk_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idles high as the pin pull-up would
  initial pin_o = 1'b1;
  task automatic pulse(input int cnt);
    repeat (cnt)
    begin
      pin_o = 1'b0;
      repeat (2) @(negedge clk_i);
      pin_o = 1'b1;
      repeat (2) @(negedge clk_i);
    end
  endtask
endmodule

// [tb/mdt_timer_test.sv]
// Self-checking bench for the multimode down timer
module mdt_timer_test
  import mdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       RESET_I = 1'b1;
  logic [7:0] ADDR_I = ADDR_COUNT_HIGH;
  logic [7:0] WDATA_I = 8'h00;
  logic       WR_I = 1'b0;
  logic       RD_I = 1'b1;
  logic       GLOBAL_IRQ_EN_I = 1'b1;
  logic       GPIO_OUT_I = 1'b1;
  logic       GPIO_OE_N_I = 1'b0;
  logic       GPIO_DATA_WR_I = 1'b0;
  logic [7:0] RDATA_O;
  logic       TIMER_IRQ_O;
  logic       SHARED_IO_PIN_I;
  logic       SHARED_IO_PIN_O;
  logic       SHARED_IO_PIN_OE_N_O;
  logic [7:0] d;
  int         n;
  int         irqs = 0;
  int         mismatches = 0;
  int         checks_done = 0;
  always #25 clk = ~clk;
  always @(negedge clk) if (TIMER_IRQ_O === 1'b1) irqs++;
  mdt_timer uut (
    .CORE_CLK_I          (clk),
    .RESET_I             (RESET_I),
    .ADDR_I              (ADDR_I),
    .WDATA_I             (WDATA_I),
    .WR_I                (WR_I),
    .RD_I                (RD_I),
    .RDATA_O             (RDATA_O),
    .GLOBAL_IRQ_EN_I     (GLOBAL_IRQ_EN_I),
    .TIMER_IRQ_O         (TIMER_IRQ_O),
    .SHARED_IO_PIN_I     (SHARED_IO_PIN_I),
    .GPIO_OUT_I          (GPIO_OUT_I),
    .GPIO_OE_N_I         (GPIO_OE_N_I),
    .GPIO_DATA_WR_I      (GPIO_DATA_WR_I),
    .SHARED_IO_PIN_O     (SHARED_IO_PIN_O),
    .SHARED_IO_PIN_OE_N_O(SHARED_IO_PIN_OE_N_O)
  );
  mdt_pin_source pm (.clk_i(clk), .pin_o(SHARED_IO_PIN_I));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Strobe stays up between back-to-back accesses
  task automatic bus(input logic w, input logic [7:0] a, v,
                     output logic [7:0] r);
    WR_I = w;
    RD_I = ~w;
    ADDR_I = a;
    WDATA_I = v;
    @(negedge clk);
    r = RDATA_O;
  endtask
  task automatic off();
    WR_I = 1'b0;
    RD_I = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_reset();
    repeat (4) @(negedge clk);
    RESET_I = 1'b0;
    GPIO_DATA_WR_I = 1'b1;
    @(negedge clk);
    GPIO_DATA_WR_I = 1'b0;
    chk(RDATA_O, 16'h00FF);
    chk(SHARED_IO_PIN_O, 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, 8'(ADDR_RELOAD_LOW + i), 8'h00, d);
      chk(d, (i == 2 || i == 3) ? 16'h00FF : 16'h0000);
    end
    bus(1'b1, ADDR_CONTROL, 8'h87, d);
    bus(1'b0, ADDR_CONTROL, 8'h00, d);
    chk(d, 16'h0084);
  endtask
  task automatic t_pwm();
    logic [7:0] cv [3] = '{8'hB4, 8'hB4, 8'h90};
    bus(1'b1, ADDR_RELOAD_LOW, 8'h03, d);
    bus(1'b1, ADDR_COUNT_LOW, 8'h02, d);
    bus(1'b1, ADDR_COUNT_HIGH, 8'h00, d);
    bus(1'b1, ADDR_CONTROL, 8'hB4, d);
    off();
    repeat (3) @(negedge clk);
    bus(1'b0, ADDR_COUNT_LOW, 8'h00, d);
    chk(d, 16'h0002);
    bus(1'b0, ADDR_CONTROL, 8'h00, d);
    chk(d, 16'h00BC);
    chk(SHARED_IO_PIN_O, 16'h0000);
    off();
    repeat (8) @(negedge clk);
    chk(16'(irqs), 16'h0001);
    // Both enables, then global enable off, then timer enable off
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, ADDR_CONTROL, 8'h00, d);
      off();
      GLOBAL_IRQ_EN_I = (i != 1);
      n = irqs;
      bus(1'b1, ADDR_COUNT_LOW, 8'h00, d);
      bus(1'b1, ADDR_CONTROL, cv[i], d);
      off();
      repeat (3) @(negedge clk);
      chk(16'(irqs - n), (i == 0) ? 16'h0001 : 16'h0000);
    end
  endtask
  task automatic t_event();
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, ADDR_CONTROL, 8'h00, d);
      bus(1'b1, ADDR_COUNT_LOW, 8'h05, d);
      bus(1'b1, ADDR_CONTROL, i ? 8'h30 : 8'h10, d);
      off();
      pm.pulse(3);
      repeat (4) @(negedge clk);
      bus(1'b0, ADDR_COUNT_LOW, 8'h00, d);
      chk(d, 16'h0002);
    end
  endtask
  task automatic t_capture();
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, ADDR_COUNT_LOW, 8'hFF, d);
      bus(1'b1, ADDR_COUNT_HIGH, 8'hFF, d);
      bus(1'b1, ADDR_CONTROL, i ? 8'h64 : 8'h44, d);
      off();
      n = irqs;
      pm.pulse(1);
      repeat (4) @(negedge clk);
      bus(1'b0, ADDR_RELOAD_HIGH, 8'h00, d);
      chk(d, 16'h00FF);
      bus(1'b0, ADDR_CONTROL, 8'h00, d);
      chk(d, i ? 16'h006C : 16'h004C);
      off();
      chk(16'(irqs - n), 16'h0001);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial
  begin
    t_reset();
    t_pwm();
    t_event();
    t_capture();
    summarize();
  end
endmodule
